// ### verilog/lsds_defines.vh
// Purpose: constants for the standby, display switch and scroll command block
// Assumes: included by bare name from the design files
// Notes: command codes and parameter byte layout are local choices
`ifndef LSDS_DEFINES_VH
`define LSDS_DEFINES_VH

// ----------------------------------------
// command codes
// ----------------------------------------
`define LSDS_CMD_STANDBY 8'h10
`define LSDS_CMD_SYSCFG 8'h20
`define LSDS_CMD_DISP 7'h18
`define LSDS_CMD_SCROLL 8'h40
`define LSDS_CMD_MEMWR 8'h50

// ----------------------------------------
// display switch parameter layout
// ----------------------------------------
`define LSDS_CUR_LSB 0
`define LSDS_BLK1_LSB 2
`define LSDS_BLK2_LSB 4
`define LSDS_BLK3_LSB 6

// ----------------------------------------
// scroll parameter indices
// ----------------------------------------
`define LSDS_SCR_COUNT 4'd10
`define LSDS_SCR_A1 0
`define LSDS_SCR_L1 2
`define LSDS_SCR_A2 3
`define LSDS_SCR_L2 5
`define LSDS_SCR_A3 6
`define LSDS_SCR_A4 8

// ----------------------------------------
// reset values and timing counts
// ----------------------------------------
`define LSDS_RST_ATTR 8'h00
`define LSDS_RST_DISP 1'b0
`define LSDS_RST_BYTE 8'h00
`define LSDS_BLANK_TICKS 2'h2
`define LSDS_CUR32_ON 6'h16
`define LSDS_CUR64_ON 6'h2c

`endif

// ### verilog/lsds_flash.v
// Purpose: frame counter and flash phases for cursor and screen blocks
// Assumes: frame_tick is a one-cycle pulse once per frame
// Notes: counter freezes when run is low, so phases survive standby
`timescale 1ns/1ps
`include "lsds_defines.vh"
module lsds_flash (
   input wire clk,
   input wire rst,
   input wire frame_tick,
   input wire run,
   output reg cur_on32,
   output reg cur_on64,
   output reg blk_on32,
   output reg blk_on4
);
   reg [5:0] frame_count;
   wire [5:0] next_count;

   // ----------------------------------------
   // frame counter
   // ----------------------------------------
   assign next_count = frame_count + 6'h01;

   always @(posedge clk) begin
      if (rst) begin
         frame_count <= 6'h00;
         cur_on32 <= 1'b1;
         cur_on64 <= 1'b1;
         blk_on32 <= 1'b1;
         blk_on4 <= 1'b1;
      end else if (run && frame_tick) begin
         frame_count <= next_count;
         // 22 of 32 and 44 of 64 frames lit, both 68.75 pct, the most whole frames that stay under 70 pct
         cur_on32 <= (next_count[4:0] < `LSDS_CUR32_ON);
         cur_on64 <= (next_count < `LSDS_CUR64_ON);
         blk_on32 <= ~next_count[4];
         blk_on4 <= ~next_count[1];
      end
   end
endmodule

// ### verilog/lsds_top.v
// Purpose: standby, display switch and scroll command handling
// Assumes: host writes arrive as one-cycle strobes synchronous to SYS_CLK
// Notes: frame ticks come from the timing generator and stop in sleep
`timescale 1ns/1ps
`include "lsds_defines.vh"
module lsds_top (
   input wire SYS_CLK,
   input wire RST,
   input wire HOST_WR,
   input wire HOST_A0,
   input wire [7:0] HOST_DIN,
   input wire FRAME_TICK,
   input wire DUAL_PANEL,
   input wire TWO_LAYER,
   input wire CURSOR_LINE_MODE,
   output reg ASLEEP,
   output reg OSC_RUN,
   output reg BLANK_PIXELS,
   output reg ROW_DRIVER_DISABLE_N,
   output reg MEM_CTRL_HOLD,
   output reg HOST_BUS_OE_N,
   output reg DISPLAY_ENABLE,
   output reg CURSOR_VISIBLE,
   output reg CURSOR_WHOLE_LINE,
   output reg BLOCK1_VISIBLE,
   output reg BLOCK2_VISIBLE,
   output reg BLOCK3_VISIBLE,
   output reg BLOCK4_VISIBLE,
   output wire [15:0] FIRST_BLOCK_START_ADDRESS,
   output wire [15:0] SECOND_BLOCK_START_ADDRESS,
   output wire [15:0] THIRD_BLOCK_START_ADDRESS,
   output wire [15:0] FOURTH_BLOCK_START_ADDRESS,
   output wire FOURTH_BLOCK_USED,
   output reg [8:0] FIRST_BLOCK_HEIGHT,
   output reg [8:0] SECOND_BLOCK_HEIGHT
);

   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam ST_RUN = 2'b00;
   localparam ST_BLANK = 2'b01;
   localparam ST_SLEEP = 2'b10;
   localparam ST_WAKE = 2'b11;

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   reg [1:0] state;
   reg [1:0] next_state;
   reg [1:0] blank_ticks;
   reg [7:0] cur_cmd;
   reg [3:0] par_idx;
   reg [7:0] attr;
   reg disp_en;
   reg cursor_force;
   reg [7:0] scroll_par [0:9];
   integer i;

   wire cmd_wr;
   wire par_wr;
   wire is_standby;
   wire is_syscfg;
   wire is_disp;
   wire is_scroll;
   wire is_memwr;
   wire cur_on32;
   wire cur_on64;
   wire blk_on32;
   wire blk_on4;
   wire awake;
   wire [1:0] cursor_flash_field;
   wire [5:0] block_attribute_field;
   wire next_cursor;
   wire next_blk1;
   wire next_blk2;
   wire next_blk3;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function blk_vis;
      input [1:0] mode;
      input on32;
      input on4;
      begin
         case (mode)
            2'b00: blk_vis = 1'b0;
            2'b01: blk_vis = 1'b1;
            2'b10: blk_vis = on32;
            default: blk_vis = on4;
         endcase
      end
   endfunction

   function sleeping;
      input [1:0] st;
      begin
         sleeping = (st == ST_SLEEP) || (st == ST_WAKE);
      end
   endfunction

   function clocked;
      input [1:0] st;
      begin
         clocked = (st == ST_RUN) || (st == ST_BLANK);
      end
   endfunction

   function [15:0] join_bytes;
      input [7:0] hi;
      input [7:0] lo;
      begin
         join_bytes = {hi, lo};
      end
   endfunction

   function [8:0] height;
      input [7:0] count;
      begin
         height = {1'b0, count} + 9'h001;
      end
   endfunction

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   assign cmd_wr = HOST_WR & HOST_A0;
   assign par_wr = HOST_WR & ~HOST_A0;
   assign is_standby = (HOST_DIN == `LSDS_CMD_STANDBY);
   assign is_syscfg = (HOST_DIN == `LSDS_CMD_SYSCFG);
   assign is_disp = (HOST_DIN[7:1] == `LSDS_CMD_DISP);
   assign is_scroll = (HOST_DIN == `LSDS_CMD_SCROLL);
   assign is_memwr = (HOST_DIN == `LSDS_CMD_MEMWR);
   assign awake = (state == ST_RUN);

   // ----------------------------------------
   // flash timebase
   // ----------------------------------------
   lsds_flash u_flash (
      .clk(SYS_CLK),
      .rst(RST),
      .frame_tick(FRAME_TICK),
      .run(awake),
      .cur_on32(cur_on32),
      .cur_on64(cur_on64),
      .blk_on32(blk_on32),
      .blk_on4(blk_on4)
   );

   // ----------------------------------------
   // standby sequencer
   // ----------------------------------------
   always @* begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (cmd_wr && is_standby) begin
               next_state = ST_BLANK;
            end
         end
         ST_BLANK: begin
            // second tick: one full blank frame has gone by
            if (FRAME_TICK && blank_ticks == `LSDS_BLANK_TICKS - 2'h1) begin
               next_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (cmd_wr && is_syscfg) begin
               next_state = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (par_wr) begin
               next_state = ST_RUN;
            end else if (cmd_wr && !is_syscfg) begin
               next_state = ST_SLEEP;
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   always @(posedge SYS_CLK) begin
      if (RST) begin
         state <= ST_RUN;
         blank_ticks <= 2'h0;
      end else begin
         state <= next_state;
         if (state != ST_BLANK) begin
            blank_ticks <= 2'h0;
         end else if (FRAME_TICK) begin
            blank_ticks <= blank_ticks + 2'h1;
         end
      end
   end

   // ----------------------------------------
   // command and parameter registers
   // ----------------------------------------
   // writes are only taken while running, so sleep keeps every setting
   always @(posedge SYS_CLK) begin
      if (RST) begin
         cur_cmd <= `LSDS_RST_BYTE;
         par_idx <= 4'h0;
         disp_en <= `LSDS_RST_DISP;
         cursor_force <= 1'b0;
      end else if (awake) begin
         if (cmd_wr) begin
            cur_cmd <= HOST_DIN;
            par_idx <= 4'h0;
            cursor_force <= is_memwr;
            if (is_disp) begin
               disp_en <= HOST_DIN[0];
            end
         end else if (par_wr && par_idx != `LSDS_SCR_COUNT) begin
            par_idx <= par_idx + 4'h1;
         end
      end
   end

   // ----------------------------------------
   // display switch attribute byte
   // ----------------------------------------
   // a standby code owns no parameter, so stray bytes fall through
   always @(posedge SYS_CLK) begin
      if (RST) begin
         attr <= `LSDS_RST_ATTR;
      end else if (awake && par_wr) begin
         if (cur_cmd[7:1] == `LSDS_CMD_DISP && par_idx == 4'h0) begin
            attr <= HOST_DIN;
         end
      end
   end

   // ----------------------------------------
   // scroll parameter bytes
   // ----------------------------------------
   // a new code ends the sequence early, untouched entries stay
   always @(posedge SYS_CLK) begin
      if (RST) begin
         for (i = 0; i < 10; i = i + 1) begin
            scroll_par[i] <= `LSDS_RST_BYTE;
         end
      end else if (awake && par_wr) begin
         if (cur_cmd == `LSDS_CMD_SCROLL && par_idx != `LSDS_SCR_COUNT) begin
            scroll_par[par_idx] <= HOST_DIN;
         end
      end
   end

   // ----------------------------------------
   // scroll outputs
   // ----------------------------------------
   assign FIRST_BLOCK_START_ADDRESS = join_bytes(scroll_par[`LSDS_SCR_A1 + 1],
      scroll_par[`LSDS_SCR_A1]);
   assign SECOND_BLOCK_START_ADDRESS = join_bytes(scroll_par[`LSDS_SCR_A2 + 1],
      scroll_par[`LSDS_SCR_A2]);
   assign THIRD_BLOCK_START_ADDRESS = join_bytes(scroll_par[`LSDS_SCR_A3 + 1],
      scroll_par[`LSDS_SCR_A3]);
   assign FOURTH_BLOCK_START_ADDRESS = join_bytes(scroll_par[`LSDS_SCR_A4 + 1],
      scroll_par[`LSDS_SCR_A4]);
   assign FOURTH_BLOCK_USED = DUAL_PANEL & TWO_LAYER;

   always @(posedge SYS_CLK) begin
      if (RST) begin
         FIRST_BLOCK_HEIGHT <= 9'h001;
         SECOND_BLOCK_HEIGHT <= 9'h001;
      end else begin
         FIRST_BLOCK_HEIGHT <= height(scroll_par[`LSDS_SCR_L1]);
         SECOND_BLOCK_HEIGHT <= height(scroll_par[`LSDS_SCR_L2]);
      end
   end

   // ----------------------------------------
   // visibility
   // ----------------------------------------
   assign cursor_flash_field = attr[`LSDS_CUR_LSB + 1:`LSDS_CUR_LSB];
   assign block_attribute_field = attr[`LSDS_BLK3_LSB + 1:`LSDS_BLK1_LSB];

   // memory write forces the cursor lit whatever the flash mode, while display is on
   assign next_cursor = disp_en & (cursor_force |
      blk_vis(cursor_flash_field, cur_on32, cur_on64));
   assign next_blk1 = disp_en & blk_vis(block_attribute_field[1:0], blk_on32, blk_on4);
   assign next_blk2 = disp_en & blk_vis(block_attribute_field[3:2], blk_on32, blk_on4);
   assign next_blk3 = disp_en & blk_vis(block_attribute_field[5:4], blk_on32, blk_on4);

   always @(posedge SYS_CLK) begin
      if (RST) begin
         DISPLAY_ENABLE <= `LSDS_RST_DISP;
         CURSOR_VISIBLE <= 1'b0;
         CURSOR_WHOLE_LINE <= 1'b0;
         BLOCK1_VISIBLE <= 1'b0;
         BLOCK2_VISIBLE <= 1'b0;
         BLOCK3_VISIBLE <= 1'b0;
         BLOCK4_VISIBLE <= 1'b0;
      end else if (awake) begin
         DISPLAY_ENABLE <= disp_en;
         CURSOR_VISIBLE <= next_cursor;
         CURSOR_WHOLE_LINE <= CURSOR_LINE_MODE;
         BLOCK1_VISIBLE <= next_blk1;
         BLOCK2_VISIBLE <= next_blk2;
         BLOCK3_VISIBLE <= next_blk3;
         // no attribute of its own, it follows the second block while DUAL_PANEL is high, else stays off
         BLOCK4_VISIBLE <= DUAL_PANEL & next_blk2;
      end
   end

   // ----------------------------------------
   // power control
   // ----------------------------------------
   always @(posedge SYS_CLK) begin
      if (RST) begin
         ASLEEP <= 1'b0;
         OSC_RUN <= 1'b1;
         BLANK_PIXELS <= 1'b1;
      end else begin
         ASLEEP <= sleeping(next_state);
         OSC_RUN <= clocked(next_state);
         // blank from the standby code onward, and whenever display is off
         BLANK_PIXELS <= (next_state != ST_RUN) || !disp_en;
      end
   end

   // ----------------------------------------
   // pin control
   // ----------------------------------------
   always @(posedge SYS_CLK) begin
      if (RST) begin
         ROW_DRIVER_DISABLE_N <= 1'b1;
         MEM_CTRL_HOLD <= 1'b0;
         HOST_BUS_OE_N <= 1'b0;
      end else begin
         // low lands on the second frame tick after the code
         ROW_DRIVER_DISABLE_N <= clocked(next_state);
         MEM_CTRL_HOLD <= sleeping(next_state);
         // pull resistors set the bus level while released
         HOST_BUS_OE_N <= sleeping(next_state);
      end
   end

endmodule

// ### sim/lsds_host.sv
// Purpose: host model writing command and parameter bytes
// Assumes: one byte taken per rising edge while wr is high
// Notes: lines change at the falling edge only
`timescale 1ns/1ps
module lsds_host (
   input wire clk,
   output reg wr,
   output reg a0,
   output reg [7:0] din
);
   initial begin
      wr = 1'b0;
      a0 = 1'b0;
      din = 8'h00;
   end
   // ----------------------------------------
   // byte transfers
   // ----------------------------------------
   task put(input a0v, input [7:0] d);
      begin
         @(negedge clk);
         wr = 1'b1;
         a0 = a0v;
         din = d;
         @(posedge clk);
      end
   endtask
   // released data must not keep the last byte
   task idle;
      begin
         @(negedge clk);
         wr = 1'b0;
         din = ~din;
      end
   endtask
   // code byte, then n parameters in fixed order, low byte of p first
   task cmd(input [7:0] code, input integer n, input [79:0] p);
      integer i;
      begin
         put(1'b1, code);
         for (i = 0; i < n; i = i + 1) put(1'b0, p[8*i +: 8]);
         idle;
      end
   endtask
endmodule

// ### sim/lsds_top_checker.sv
// Purpose: port assertions for the standby and display block
// Assumes: one clock, sync reset
// Notes: sleep timing is tied to frame ticks
`timescale 1ns/1ps
module lsds_top_checker (
   input wire SYS_CLK,
   input wire RST,
   input wire HOST_WR,
   input wire HOST_A0,
   input wire [7:0] HOST_DIN,
   input wire FRAME_TICK,
   input wire DUAL_PANEL,
   input wire TWO_LAYER,
   input wire CURSOR_LINE_MODE,
   input wire ASLEEP,
   input wire OSC_RUN,
   input wire BLANK_PIXELS,
   input wire ROW_DRIVER_DISABLE_N,
   input wire MEM_CTRL_HOLD,
   input wire HOST_BUS_OE_N,
   input wire DISPLAY_ENABLE,
   input wire CURSOR_VISIBLE,
   input wire CURSOR_WHOLE_LINE,
   input wire BLOCK1_VISIBLE,
   input wire BLOCK2_VISIBLE,
   input wire BLOCK3_VISIBLE,
   input wire BLOCK4_VISIBLE,
   input wire FOURTH_BLOCK_USED
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // ----------------------------------------
   // sequences
   // ----------------------------------------
   sequence wake_seq;
      ASLEEP && HOST_WR && HOST_A0 && HOST_DIN == 8'h20 ##1 HOST_WR && !HOST_A0;
   endsequence
   sequence standby_seq;
      !ASLEEP && HOST_WR && HOST_A0 && HOST_DIN == 8'h10;
   endsequence
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_wake_leaves_sleep: assert property (wake_seq |=> !ASLEEP)
      else $error("sleep not left after wake bytes");
   a_standby_blanks: assert property (standby_seq |=> BLANK_PIXELS [*3])
      else $error("pixels not blanked on standby");
   a_sleep_after_tick: assert property ($rose(ASLEEP) |-> $past(FRAME_TICK) && $past(BLANK_PIXELS))
      else $error("sleep entered off a frame tick");
   a_rowdis_tracks: assert property (ROW_DRIVER_DISABLE_N == !ASLEEP && HOST_BUS_OE_N == ASLEEP)
      else $error("row disable or bus release wrong");
   a_halt_hold: assert property (ASLEEP |-> !OSC_RUN && MEM_CTRL_HOLD)
      else $error("oscillator or memory pins active in sleep");
   a_sleep_keeps_enable: assert property (ASLEEP && $past(ASLEEP) |-> $stable(DISPLAY_ENABLE))
      else $error("display enable changed in sleep");
   a_off_dark: assert property (!DISPLAY_ENABLE && !$past(DISPLAY_ENABLE) |->
      !(CURSOR_VISIBLE || BLOCK1_VISIBLE || BLOCK2_VISIBLE || BLOCK3_VISIBLE || BLOCK4_VISIBLE))
      else $error("something lit while display off");
   a_block4_follows: assert property ($stable(DUAL_PANEL) |->
      BLOCK4_VISIBLE == (DUAL_PANEL && BLOCK2_VISIBLE))
      else $error("block four not following block two");
   a_fourth_used: assert property (FOURTH_BLOCK_USED == (DUAL_PANEL && TWO_LAYER))
      else $error("fourth block use flag wrong");
   a_line_mode_copy: assert property (CURSOR_WHOLE_LINE == $past(CURSOR_LINE_MODE))
      else $error("cursor line mode not copied");
endmodule
bind lsds_top lsds_top_checker lsds_top_checker_inst (.SYS_CLK(SYS_CLK), .RST(RST),
   .HOST_WR(HOST_WR), .HOST_A0(HOST_A0), .HOST_DIN(HOST_DIN), .FRAME_TICK(FRAME_TICK),
   .DUAL_PANEL(DUAL_PANEL), .TWO_LAYER(TWO_LAYER), .CURSOR_LINE_MODE(CURSOR_LINE_MODE),
   .ASLEEP(ASLEEP), .OSC_RUN(OSC_RUN), .BLANK_PIXELS(BLANK_PIXELS),
   .ROW_DRIVER_DISABLE_N(ROW_DRIVER_DISABLE_N), .MEM_CTRL_HOLD(MEM_CTRL_HOLD),
   .HOST_BUS_OE_N(HOST_BUS_OE_N), .DISPLAY_ENABLE(DISPLAY_ENABLE),
   .CURSOR_VISIBLE(CURSOR_VISIBLE), .CURSOR_WHOLE_LINE(CURSOR_WHOLE_LINE),
   .BLOCK1_VISIBLE(BLOCK1_VISIBLE), .BLOCK2_VISIBLE(BLOCK2_VISIBLE),
   .BLOCK3_VISIBLE(BLOCK3_VISIBLE), .BLOCK4_VISIBLE(BLOCK4_VISIBLE),
   .FOURTH_BLOCK_USED(FOURTH_BLOCK_USED));

// ### sim/test_lcd_sleep_display_scroll_cmds.sv
// Purpose: self-checking bench for the standby, display and scroll block
// Assumes: frame tick every four clocks
// Notes: flash counts are taken over 64 frames so phase does not matter
`timescale 1ns/1ps
module test_lcd_sleep_display_scroll_cmds;
   reg SYS_CLK, RST, FRAME_TICK, DUAL_PANEL, TWO_LAYER, CURSOR_LINE_MODE;
   reg [1:0] div;
   integer err_total, cmp_count, m;
   wire HOST_WR, HOST_A0, ASLEEP, OSC_RUN, BLANK_PIXELS, ROW_DRIVER_DISABLE_N, MEM_CTRL_HOLD;
   wire HOST_BUS_OE_N, DISPLAY_ENABLE, CURSOR_VISIBLE, CURSOR_WHOLE_LINE, FOURTH_BLOCK_USED;
   wire BLOCK1_VISIBLE, BLOCK2_VISIBLE, BLOCK3_VISIBLE, BLOCK4_VISIBLE;
   wire [7:0] HOST_DIN;
   wire [15:0] A1, A2, A3, A4;
   wire [8:0] H1, H2;
   wire [4:0] vis = {BLOCK4_VISIBLE, BLOCK3_VISIBLE, BLOCK2_VISIBLE, BLOCK1_VISIBLE, CURSOR_VISIBLE};
   lsds_host lsds_host_inst (.clk(SYS_CLK), .wr(HOST_WR), .a0(HOST_A0), .din(HOST_DIN));
   lsds_top lsds_top_inst (.SYS_CLK(SYS_CLK), .RST(RST), .HOST_WR(HOST_WR), .HOST_A0(HOST_A0),
      .HOST_DIN(HOST_DIN), .FRAME_TICK(FRAME_TICK), .DUAL_PANEL(DUAL_PANEL),
      .TWO_LAYER(TWO_LAYER), .CURSOR_LINE_MODE(CURSOR_LINE_MODE), .ASLEEP(ASLEEP),
      .OSC_RUN(OSC_RUN), .BLANK_PIXELS(BLANK_PIXELS), .ROW_DRIVER_DISABLE_N(ROW_DRIVER_DISABLE_N),
      .MEM_CTRL_HOLD(MEM_CTRL_HOLD), .HOST_BUS_OE_N(HOST_BUS_OE_N),
      .DISPLAY_ENABLE(DISPLAY_ENABLE), .CURSOR_VISIBLE(CURSOR_VISIBLE),
      .CURSOR_WHOLE_LINE(CURSOR_WHOLE_LINE), .BLOCK1_VISIBLE(BLOCK1_VISIBLE),
      .BLOCK2_VISIBLE(BLOCK2_VISIBLE), .BLOCK3_VISIBLE(BLOCK3_VISIBLE),
      .BLOCK4_VISIBLE(BLOCK4_VISIBLE), .FIRST_BLOCK_START_ADDRESS(A1),
      .SECOND_BLOCK_START_ADDRESS(A2), .THIRD_BLOCK_START_ADDRESS(A3),
      .FOURTH_BLOCK_START_ADDRESS(A4), .FOURTH_BLOCK_USED(FOURTH_BLOCK_USED),
      .FIRST_BLOCK_HEIGHT(H1), .SECOND_BLOCK_HEIGHT(H2));
   // ----------------------------------------
   // clock, frame ticks, checking
   // ----------------------------------------
   initial begin
      SYS_CLK = 1'b0;
      forever #10 SYS_CLK = ~SYS_CLK;
   end
   always @(negedge SYS_CLK) begin
      div <= div + 2'h1;
      FRAME_TICK <= (div == 2'h3);
   end
   task chk(input [47:0] seen, input [47:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task tick;
      begin
         @(posedge SYS_CLK);
         while (FRAME_TICK !== 1'b1) @(posedge SYS_CLK);
         #1;
      end
   endtask
   task summarize;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, err_total);
         if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task flash_modes;
      reg [4:0] pv;
      reg [1:0] md;
      integer on[0:4], tg[0:4], j;
      begin
         for (m = 0; m < 4; m = m + 1) begin
            md = m;
            @(negedge SYS_CLK);
            DUAL_PANEL = md[0];
            CURSOR_LINE_MODE = md[1];
            lsds_host_inst.cmd(8'h31, 1, {72'h0, md, md, md, md});
            tick;
            tick;
            pv = vis;
            for (j = 0; j < 5; j = j + 1) on[j] = 0;
            for (j = 0; j < 5; j = j + 1) tg[j] = 0;
            repeat (64) begin
               tick;
               for (j = 0; j < 5; j = j + 1) on[j] = on[j] + vis[j];
               for (j = 0; j < 5; j = j + 1) tg[j] = tg[j] + (vis[j] != pv[j]);
               pv = vis;
            end
            chk(on[0], (32'h2c2c4000 >> (8 * md)) & 8'hff);
            chk(tg[0], (32'h02040000 >> (8 * md)) & 8'hff);
            for (j = 1; j < 4; j = j + 1) chk(on[j], (32'h20204000 >> (8 * md)) & 8'hff);
            for (j = 1; j < 4; j = j + 1) chk(tg[j], (32'h20040000 >> (8 * md)) & 8'hff);
            chk(on[4], md[0] ? on[2] : 0);
            chk(CURSOR_WHOLE_LINE, md[1]);
         end
      end
   endtask
   task off_and_write;
      begin
         lsds_host_inst.cmd(8'h30, 1, {72'h0, 8'h55});
         tick;
         chk({DISPLAY_ENABLE, vis}, 6'h00);
         lsds_host_inst.cmd(8'h31, 1, {72'h0, 8'h54});
         repeat (3) @(posedge SYS_CLK);
         #1;
         chk(vis[1:0], 2'b10);
         lsds_host_inst.cmd(8'h50, 0, 80'h0);
         repeat (3) @(posedge SYS_CLK);
         #1;
         chk(CURSOR_VISIBLE, 1'b1);
      end
   endtask
   task scroll_load;
      begin
         @(negedge SYS_CLK);
         TWO_LAYER = 1'b1;
         DUAL_PANEL = 1'b1;
         lsds_host_inst.cmd(8'h40, 10, 80'hd4c4_b3a3_ff_9282_00_7161);
         @(posedge SYS_CLK);
         #1;
         chk(A1, 16'h7161);
         chk(A2, 16'h9282);
         chk(A3, 16'hb3a3);
         chk(A4, 16'hd4c4);
         chk({H1, H2}, {9'h001, 9'h100});
         chk(FOURTH_BLOCK_USED, 1'b1);
         lsds_host_inst.cmd(8'h40, 3, {56'h0, 24'h7e_1234});
         @(posedge SYS_CLK);
         #1;
         chk(A1, 16'h1234);
         chk({A2, H1, H2}, {16'h9282, 9'h07f, 9'h100});
      end
   endtask
   task standby_wake;
      begin
         lsds_host_inst.cmd(8'h10, 0, 80'h0);
         chk(BLANK_PIXELS, 1'b1);
         tick;
         chk(ASLEEP, 1'b0);
         tick;
         repeat (2) @(posedge SYS_CLK);
         #1;
         chk({ASLEEP, OSC_RUN, ROW_DRIVER_DISABLE_N, MEM_CTRL_HOLD, HOST_BUS_OE_N}, 5'h13);
         lsds_host_inst.cmd(8'h40, 1, 80'h0);
         chk(A1, 16'h1234);
         lsds_host_inst.cmd(8'h20, 1, {72'h0, 8'h30});
         @(posedge SYS_CLK);
         #1;
         chk({ASLEEP, ROW_DRIVER_DISABLE_N, HOST_BUS_OE_N}, 3'b010);
         lsds_host_inst.cmd(8'h31, 1, {72'h0, 8'h54});
         repeat (3) @(posedge SYS_CLK);
         #1;
         chk({BLANK_PIXELS, BLOCK1_VISIBLE, H1}, {2'b01, 9'h07f});
      end
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      err_total = 0;
      cmp_count = 0;
      RST = 1'b1;
      div = 2'h0;
      FRAME_TICK = 1'b0;
      DUAL_PANEL = 1'b0;
      TWO_LAYER = 1'b0;
      CURSOR_LINE_MODE = 1'b0;
      repeat (6) @(negedge SYS_CLK);
      RST = 1'b0;
      chk({ASLEEP, OSC_RUN, BLANK_PIXELS, ROW_DRIVER_DISABLE_N, HOST_BUS_OE_N, H1}, {5'h0e, 9'h001});
      flash_modes;
      off_and_write;
      scroll_load;
      standby_wake;
      summarize;
   end
   // whole run is near 1120 clocks, so 20000 means a hang
   initial begin
      #400000;
      err_total = err_total + 1;
      summarize;
   end
endmodule
